/* prt_pkg.sv */
`default_nettype none
package prt_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_RELOC = 8'h00;
    localparam logic [7:0] OFF_CTX = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_LOCK = 8'h0C;
    localparam logic [7:0] OFF_DOM = 8'h10;
    localparam logic [7:0] OFF_INV_ALL = 8'h14;
    localparam logic [7:0] OFF_INV_ONE = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;
    localparam int CTRL_MMU_EN = 0;
    localparam int LOCK_KEEP = 0;
    localparam int LOCK_VIC_LO = 26;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ABORT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ****************************************
    // Relocation and sizes
    // ****************************************
    localparam int PID_W = 7;
    localparam logic [6:0] PID_RST = 7'h00;
    localparam int SLOT_SHIFT = 25;
    localparam logic [1:0] PID_LAG = 2'h2;
    localparam int MAIN_SETS = 32;
    localparam int MAIN_WAYS = 2;
    localparam int LOCK_N = 8;
    localparam int IDX_LO = 12;
    localparam logic [21:0] MASK_SECT = 22'h3FFC00;
    localparam logic [21:0] MASK_LARGE = 22'h3FFFC0;
    localparam logic [21:0] MASK_SMALL = 22'h3FFFFC;
    localparam logic [21:0] MASK_TINY = 22'h3FFFFF;
    localparam logic [1:0] DOM_NONE = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_MANAGER = 2'h3;
    localparam logic [1:0] AP_PRIV = 2'h1;
    localparam logic [1:0] AP_URO = 2'h2;
    localparam logic [1:0] AP_FULL = 2'h3;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {PRT_SECTION, PRT_LARGE, PRT_SMALL, PRT_TINY} prt_gran_t;
    typedef struct packed {
        logic [21:0] vtag;
        prt_gran_t gran;
        logic [21:0] pbase;
        logic [3:0] dom;
        logic [7:0] ap;
        logic cach;
        logic buff;
    } prt_entry_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic user;
        logic maint;
    } prt_req_t;
    typedef struct packed {
        logic [31:0] relocated_virtual_address;
        logic [31:0] pa;
        logic abort;
        logic cach;
        logic buff;
    } prt_resp_t;
endpackage
`default_nettype wire

/* prt_perm_check.sv */
`timescale 1ns/10ps
`default_nettype none
module prt_perm_check (
    input wire logic [31:0] dom_ctl,
    input wire prt_pkg::prt_entry_t ent,
    input wire logic [31:0] relocated_virtual_address,
    input wire logic write,
    input wire logic user,
    output logic allow
);
    logic [1:0] dom_code;
    logic [1:0] sub;
    logic [1:0] ap_sel;
    logic ap_ok;

    assign dom_code = dom_ctl[2*ent.dom +: 2];

    // Quarter select only for large and small pages
    always_comb begin
        unique case (ent.gran)
            prt_pkg::PRT_LARGE: sub = relocated_virtual_address[15:14];
            prt_pkg::PRT_SMALL: sub = relocated_virtual_address[11:10];
            default: sub = 2'h0;
        endcase
    end
    assign ap_sel = ent.ap[2*sub +: 2];

    always_comb begin
        unique case (ap_sel)
            prt_pkg::AP_PRIV: ap_ok = !user;
            prt_pkg::AP_URO: ap_ok = !user || !write;
            prt_pkg::AP_FULL: ap_ok = 1'b1;
            default: ap_ok = 1'b0;
        endcase
    end

    // Reserved domain code aborts as the safe choice
    always_comb begin
        unique case (dom_code)
            prt_pkg::DOM_CLIENT: allow = ap_ok;
            prt_pkg::DOM_MANAGER: allow = 1'b1;
            default: allow = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

/* prt_reloc_tlb.sv */
// Operation
// - Core addresses below 32MB get relocation id times 32MB added.
// - Core addresses at or above 32MB pass unchanged.
// - Relocation id is seven bits, 128 slots.
// - Relocation id zero gives a flat mapping.
// - Reset clears the relocation id.
// - With translation disabled no relocation is applied.
// - Maintenance addresses bypass relocation.
// - Two accesses after an id write still use the old id.
// - Relocation id and context id are readable and writable registers.
// - Context id drives the trace id pins continuously.
// - Each context id write gives one strobe pulse.
// - One unified buffer serves instruction and data accesses.
// - Main buffer is two-way, 32 sets, 64 entries.
// - Eight-entry fully associative lockdown buffer.
// - Sections, large, small and tiny page granules.
// - Large and small pages carry per-quarter permissions.
// - Sixteen domains: check, always allow or always abort.
// - Hit gives physical address or abort.
// - Miss starts table walk and writes the result.
// - Lockdown control picks the walk result destination.
// - Invalidate all and invalidate one by relocated address.
// - After reset translation off, noncacheable, nonbufferable.
// - Keep flag set writes lockdown at victim, else main.
// - Victim increments after each lockdown write, except when the lock register is written in that cycle.
// - Invalidate all spares locked entries; single hits both.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module prt_reloc_tlb #(
    parameter int SETS = prt_pkg::MAIN_SETS,
    parameter int LOCKS = prt_pkg::LOCK_N
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire prt_pkg::prt_req_t core_req,
    output logic core_resp_valid,
    output prt_pkg::prt_resp_t core_resp,
    output logic walk_req,
    output logic [31:0] walk_mva,
    input wire logic walk_done,
    input wire logic walk_fault,
    input wire prt_pkg::prt_entry_t walk_entry,
    output logic [31:0] trace_process_id_out,
    output logic trace_process_id_write_strobe
);
    localparam int IW = $clog2(SETS);
    localparam int VW = $clog2(LOCKS);
    typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_RESP} prt_state_t;

    // ****************************************
    // Bus slave
    // ****************************************
    logic dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic [6:0] pid_reg;
    logic [6:0] pid_act_reg;
    logic [1:0] lag_reg;
    logic [31:0] ctx_reg;
    logic mmu_en_reg;
    logic keep_reg;
    logic [VW-1:0] victim_reg;
    logic [31:0] dom_reg;
    logic strobe_reg;
    logic abort_reg;
    logic take;
    logic wr_now;
    logic inv_all;
    logic inv_one;
    prt_state_t state_reg;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready && hsize == prt_pkg::HSIZE_WORD;
    assign wr_now = dp_wr_reg;
    assign inv_all = wr_now && dp_addr_reg == prt_pkg::OFF_INV_ALL;
    assign inv_one = wr_now && dp_addr_reg == prt_pkg::OFF_INV_ONE;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_wr_reg <= take && hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    // Read data is ready in the data phase with no wait states
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= 32'h00000000;
            unique case (haddr[7:0])
                prt_pkg::OFF_RELOC: hrdata[prt_pkg::PID_W-1:0] <= pid_reg;
                prt_pkg::OFF_CTX: hrdata <= ctx_reg;
                prt_pkg::OFF_CTRL: hrdata[prt_pkg::CTRL_MMU_EN] <= mmu_en_reg;
                prt_pkg::OFF_LOCK: begin
                    hrdata[prt_pkg::LOCK_KEEP] <= keep_reg;
                    hrdata[prt_pkg::LOCK_VIC_LO +: VW] <= victim_reg;
                end
                prt_pkg::OFF_DOM: hrdata <= dom_reg;
                prt_pkg::OFF_STAT: begin
                    hrdata[prt_pkg::STAT_BUSY] <= state_reg != ST_IDLE;
                    hrdata[prt_pkg::STAT_ABORT] <= abort_reg;
                end
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mmu_en_reg <= 1'b0;
            dom_reg <= 32'h00000000;
        end else if (wr_now && dp_addr_reg == prt_pkg::OFF_CTRL) begin
            mmu_en_reg <= hwdata[prt_pkg::CTRL_MMU_EN];
        end else if (wr_now && dp_addr_reg == prt_pkg::OFF_DOM) begin
            dom_reg <= hwdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctx_reg <= 32'h00000000;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= wr_now && dp_addr_reg == prt_pkg::OFF_CTX;
            if (wr_now && dp_addr_reg == prt_pkg::OFF_CTX) begin
                ctx_reg <= hwdata;
            end
        end
    end
    assign trace_process_id_out = ctx_reg;
    assign trace_process_id_write_strobe = strobe_reg;

    // ****************************************
    // Relocation
    // ****************************************
    logic [31:0] relocated_virtual_address;
    logic below;
    assign below = core_req.addr[31:prt_pkg::SLOT_SHIFT] == '0;

    // Old id stays live for two accesses so prefetched ops match
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pid_reg <= prt_pkg::PID_RST;
            pid_act_reg <= prt_pkg::PID_RST;
            lag_reg <= 2'h0;
        end else if (wr_now && dp_addr_reg == prt_pkg::OFF_RELOC) begin
            pid_reg <= hwdata[prt_pkg::PID_W-1:0];
            lag_reg <= prt_pkg::PID_LAG;
        end else if (lag_reg == 2'h0) begin
            pid_act_reg <= pid_reg;
        end else if (state_reg == ST_RESP) begin
            lag_reg <= lag_reg - 2'h1;
            if (lag_reg == 2'h1) begin
                pid_act_reg <= pid_reg;
            end
        end
    end

    always_comb begin
        relocated_virtual_address = core_req.addr;
        if (mmu_en_reg && !core_req.maint && below) begin
            relocated_virtual_address[31:prt_pkg::SLOT_SHIFT] = pid_act_reg;
        end
    end

    // ****************************************
    // Lookup
    // ****************************************
    prt_pkg::prt_entry_t main_mem [prt_pkg::MAIN_WAYS][SETS];
    logic [SETS-1:0] main_vld_reg [prt_pkg::MAIN_WAYS];
    prt_pkg::prt_entry_t lock_mem [LOCKS];
    logic [LOCKS-1:0] lock_vld_reg;
    logic [SETS-1:0] rr_reg;
    logic [IW-1:0] idx;
    logic [prt_pkg::MAIN_WAYS-1:0] way_hit;
    logic [LOCKS-1:0] lock_hit;
    logic hit;
    prt_pkg::prt_entry_t hit_ent;
    logic allow;

    function automatic logic [21:0] gmask(prt_pkg::prt_gran_t g);
        unique case (g)
            prt_pkg::PRT_SECTION: return prt_pkg::MASK_SECT;
            prt_pkg::PRT_LARGE: return prt_pkg::MASK_LARGE;
            prt_pkg::PRT_SMALL: return prt_pkg::MASK_SMALL;
            prt_pkg::PRT_TINY: return prt_pkg::MASK_TINY;
        endcase
    endfunction

    function automatic logic tmatch(prt_pkg::prt_entry_t e, logic [31:0] a);
        return ((e.vtag ^ a[31:10]) & gmask(e.gran)) == 22'h000000;
    endfunction

    assign idx = relocated_virtual_address[prt_pkg::IDX_LO +: IW];

    genvar gi;
    generate
        for (gi = 0; gi < prt_pkg::MAIN_WAYS; gi++) begin : g_way
            assign way_hit[gi] = main_vld_reg[gi][idx] && tmatch(main_mem[gi][idx], relocated_virtual_address);
        end
        for (gi = 0; gi < LOCKS; gi++) begin : g_lock
            assign lock_hit[gi] = lock_vld_reg[gi] && tmatch(lock_mem[gi], relocated_virtual_address);
        end
    endgenerate

    // Locked entries win; duplicates are harmless as all are equal
    always_comb begin
        hit = 1'b0;
        hit_ent = main_mem[0][idx];
        for (int w = prt_pkg::MAIN_WAYS - 1; w >= 0; w--) begin
            if (way_hit[w]) begin
                hit = 1'b1;
                hit_ent = main_mem[w][idx];
            end
        end
        for (int i = LOCKS - 1; i >= 0; i--) begin
            if (lock_hit[i]) begin
                hit = 1'b1;
                hit_ent = lock_mem[i];
            end
        end
    end

    prt_perm_check u_perm (
        .dom_ctl(dom_reg),
        .ent(hit_ent),
        .relocated_virtual_address(relocated_virtual_address),
        .write(core_req.write),
        .user(core_req.user),
        .allow(allow)
    );

    // ****************************************
    // Sequencer and fill
    // ****************************************
    logic direct;
    logic fill;
    logic [31:0] pa;
    logic [21:0] hm;
    assign direct = !mmu_en_reg || core_req.maint;
    assign fill = state_reg == ST_WALK && walk_done && !walk_fault;
    assign hm = gmask(hit_ent.gran);
    assign pa = {(hit_ent.pbase & hm) | (relocated_virtual_address[31:10] & ~hm), relocated_virtual_address[9:0]};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            core_resp <= '0;
            walk_mva <= 32'h00000000;
            abort_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (core_req.valid) begin
                    core_resp.relocated_virtual_address <= relocated_virtual_address;
                    if (direct) begin
                        core_resp.pa <= relocated_virtual_address;
                        core_resp.abort <= 1'b0;
                        core_resp.cach <= 1'b0;
                        core_resp.buff <= 1'b0;
                        state_reg <= ST_RESP;
                    end else if (hit) begin
                        core_resp.pa <= pa;
                        core_resp.abort <= !allow;
                        core_resp.cach <= hit_ent.cach;
                        core_resp.buff <= hit_ent.buff;
                        abort_reg <= !allow;
                        state_reg <= ST_RESP;
                    end else begin
                        walk_mva <= relocated_virtual_address;
                        state_reg <= ST_WALK;
                    end
                end
                ST_WALK: if (walk_done) begin
                    if (walk_fault) begin
                        core_resp.abort <= 1'b1;
                        abort_reg <= 1'b1;
                        state_reg <= ST_RESP;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RESP: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    assign walk_req = state_reg == ST_WALK;
    assign core_resp_valid = state_reg == ST_RESP;

    logic [IW-1:0] widx;
    logic [IW-1:0] iidx;
    assign widx = walk_mva[prt_pkg::IDX_LO +: IW];
    assign iidx = hwdata[prt_pkg::IDX_LO +: IW];

    // Storage arrays carry no reset; valid bits guard them
    always_ff @(posedge sys_clk) begin
        if (fill && keep_reg) begin
            lock_mem[victim_reg] <= walk_entry;
        end else if (fill) begin
            main_mem[rr_reg[widx]][widx] <= walk_entry;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            keep_reg <= 1'b0;
            victim_reg <= '0;
        end else if (wr_now && dp_addr_reg == prt_pkg::OFF_LOCK) begin
            keep_reg <= hwdata[prt_pkg::LOCK_KEEP];
            victim_reg <= hwdata[prt_pkg::LOCK_VIC_LO +: VW];
        end else if (fill && keep_reg) begin
            victim_reg <= victim_reg + VW'(1);
        end
    end

    // A fill in the same cycle as an invalidate wins for that slot
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int w = 0; w < prt_pkg::MAIN_WAYS; w++) begin
                main_vld_reg[w] <= '0;
            end
            lock_vld_reg <= '0;
            rr_reg <= '0;
        end else begin
            if (inv_all) begin
                for (int w = 0; w < prt_pkg::MAIN_WAYS; w++) begin
                    main_vld_reg[w] <= '0;
                end
            end
            if (inv_one) begin
                for (int w = 0; w < prt_pkg::MAIN_WAYS; w++) begin
                    if (tmatch(main_mem[w][iidx], hwdata)) begin
                        main_vld_reg[w][iidx] <= 1'b0;
                    end
                end
                for (int i = 0; i < LOCKS; i++) begin
                    if (tmatch(lock_mem[i], hwdata)) begin
                        lock_vld_reg[i] <= 1'b0;
                    end
                end
            end
            if (fill && keep_reg) begin
                lock_vld_reg[victim_reg] <= 1'b1;
            end else if (fill) begin
                main_vld_reg[rr_reg[widx]][widx] <= 1'b1;
                rr_reg[widx] <= !rr_reg[widx];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_pulse_once;
        trace_process_id_write_strobe ##1 !trace_process_id_write_strobe;
    endsequence
    sequence s_resp_once;
        core_resp_valid ##1 !core_resp_valid;
    endsequence

    a_reloc_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        mmu_en_reg && !core_req.maint && below
        |-> relocated_virtual_address == core_req.addr + (32'(pid_act_reg) << prt_pkg::SLOT_SHIFT))
        else $error("low address not relocated");
    a_reloc_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !below |-> relocated_virtual_address == core_req.addr)
        else $error("high address modified");
    a_reloc_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!mmu_en_reg || core_req.maint) |-> relocated_virtual_address == core_req.addr)
        else $error("relocation applied while bypassed");
    a_pid_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_now && dp_addr_reg == prt_pkg::OFF_RELOC && state_reg != ST_RESP)
        |=> pid_act_reg == $past(pid_act_reg))
        else $error("new id used too early");
    a_ctx_strobe: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_now && dp_addr_reg == prt_pkg::OFF_CTX) |=> s_pulse_once)
        else $error("context strobe not a single pulse");
    a_ctx_trace: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_now && dp_addr_reg == prt_pkg::OFF_CTX)
        |=> trace_process_id_out == $past(hwdata))
        else $error("trace pins miss context write");
    a_hit_resp: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_reg == ST_IDLE && core_req.valid && !direct && hit)
        |=> s_resp_once)
        else $error("hit without single response");
    a_miss_walk: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_reg == ST_IDLE && core_req.valid && !direct && !hit)
        |=> walk_req && walk_mva == $past(relocated_virtual_address))
        else $error("miss did not start walk");
    a_victim_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fill && keep_reg && !wr_now) |=> victim_reg == $past(victim_reg) + VW'(1))
        else $error("victim did not advance");
    a_off_attr: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (core_resp_valid && !mmu_en_reg && !$past(mmu_en_reg))
        |-> !core_resp.cach && !core_resp.buff)
        else $error("attributes set while off");
endmodule
`default_nettype wire

/* prt_walk_model.sv */
`timescale 1ns/10ps
`default_nettype none
module prt_walk_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic walk_req,
    input wire logic [31:0] walk_mva,
    input wire logic fail,
    input wire logic slow,
    output logic walk_done,
    output logic walk_fault,
    output prt_pkg::prt_entry_t walk_entry,
    output logic [31:0] walk_cnt
);
    // ****************************************
    // Table walker
    // ****************************************
    logic busy;
    logic [2:0] wait_cnt;
    prt_pkg::prt_entry_t good;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            wait_cnt <= 3'h0;
            walk_done <= 1'b0;
            walk_cnt <= 32'h0;
        end else begin
            walk_done <= 1'b0;
            // Request still high during the done pulse: no restart
            if (walk_req && !walk_done && !busy) begin
                busy <= 1'b1;
                wait_cnt <= slow ? 3'h4 : 3'h0;
            end else if (busy) begin
                if (wait_cnt == 3'h0) begin
                    walk_done <= 1'b1;
                    busy <= 1'b0;
                    walk_cnt <= walk_cnt + 32'h1;
                end else begin
                    wait_cnt <= wait_cnt - 3'h1;
                end
            end
        end
    end
    // Small page, quarter one denied, top nibble of the address flipped
    assign good = '{walk_mva[31:10], prt_pkg::PRT_SMALL, walk_mva[31:10] ^ 22'h3C0000,
                    4'h0, 8'hF3, 1'b1, 1'b1};
    // Scrambled outside the pulse so stale data cannot pass
    assign walk_entry = walk_done ? good : prt_pkg::prt_entry_t'(~good);
    assign walk_fault = walk_done & fail;
endmodule
`default_nettype wire

/* tb_prt.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, fail = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s, trc, wcnt, walk_mva;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = prt_pkg::HSIZE_WORD;
    logic rv, walk_req, walk_done, walk_fault, strobe;
    prt_pkg::prt_req_t creq = '0;
    prt_pkg::prt_resp_t resp;
    prt_pkg::prt_entry_t went;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    always #25 sys_clk = ~sys_clk;
    prt_reloc_tlb u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core_req(creq), .core_resp_valid(rv), .core_resp(resp), .walk_req(walk_req),
        .walk_mva(walk_mva), .walk_done(walk_done), .walk_fault(walk_fault),
        .walk_entry(went), .trace_process_id_out(trc), .trace_process_id_write_strobe(strobe));
    prt_walk_model u_walk (.sys_clk(sys_clk), .arst_n(arst_n), .walk_req(walk_req),
        .walk_mva(walk_mva), .fail(fail), .slow(slow), .walk_done(walk_done),
        .walk_fault(walk_fault), .walk_entry(went), .walk_cnt(wcnt));
    // ****************************************
    // Tasks
    // ****************************************
    task report_and_stop;
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wt_rdy;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd_s = hrdata;
    endtask
    // Single word transfer; address phase then data phase
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wt_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt_rdy;
        if (!w) chk(rd_s, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask
    // Core access held until the response pulse, then released
    task core(input logic [31:0] a, input logic m, input logic [31:0] emva,
              input logic [31:0] epa, input logic eab);
        @(posedge sys_clk);
        creq <= '{1'b1, a, 1'b0, 1'b0, m};
        do @(posedge sys_clk); while (rv !== 1'b1);
        chk(resp.relocated_virtual_address, emva);
        chk({31'h0, resp.abort}, {31'h0, eab});
        if (!eab) chk(resp.pa, epa);
        creq.valid <= 1'b0;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(32'h00, 32'h0);
        rd(32'h08, 32'h0);
        rd(32'h30, 32'h0);
        core(32'h100, 1'b0, 32'h100, 32'h100, 1'b0);
        chk({30'h0, resp.cach, resp.buff}, 32'h0);
        wr(32'h04, 32'hA5C3_1E87);
        @(negedge sys_clk);
        chk({31'h0, strobe}, 32'h1);
        chk(trc, 32'hA5C3_1E87);
        @(negedge sys_clk);
        chk({31'h0, strobe}, 32'h0);
        rd(32'h04, 32'hA5C3_1E87);
        wr(32'h00, 32'h83);
        rd(32'h00, 32'h03);
        core(32'h40, 1'b0, 32'h40, 32'h40, 1'b0);
        wr(32'h10, 32'h3);
        wr(32'h08, 32'h1);
        core(32'h0200_1000, 1'b0, 32'h0200_1000, 32'hF200_1000, 1'b0);
        core(32'h0200_1000, 1'b0, 32'h0200_1000, 32'hF200_1000, 1'b0);
        core(32'h1000, 1'b0, 32'h0600_1000, 32'hF600_1000, 1'b0);
        core(32'h1000, 1'b1, 32'h1000, 32'h1000, 1'b0);
        chk(wcnt, 32'h2);
        wr(32'h00, 32'h05);
        core(32'h1000, 1'b0, 32'h0600_1000, 32'hF600_1000, 1'b0);
        core(32'h1000, 1'b0, 32'h0600_1000, 32'hF600_1000, 1'b0);
        core(32'h1000, 1'b0, 32'h0A00_1000, 32'hFA00_1000, 1'b0);
        chk(wcnt, 32'h3);
        core(32'h0600_1000, 1'b0, 32'h0600_1000, 32'hF600_1000, 1'b0);
        chk({30'h0, resp.cach, resp.buff}, 32'h3);
        chk(wcnt, 32'h3);
        wr(32'h10, 32'h0);
        core(32'h1000, 1'b0, 32'h0A00_1000, 32'h0, 1'b1);
        rd(32'h1C, 32'h2);
        wr(32'h10, 32'h1);
        core(32'h1000, 1'b0, 32'h0A00_1000, 32'hFA00_1000, 1'b0);
        core(32'h1400, 1'b0, 32'h0A00_1400, 32'h0, 1'b1);
        wr(32'h10, 32'h3);
        fail <= 1'b1;
        slow <= 1'b1;
        core(32'h400, 1'b0, 32'h0A00_0400, 32'h0, 1'b1);
        fail <= 1'b0;
        wr(32'h14, 32'h0);
        core(32'h1000, 1'b0, 32'h0A00_1000, 32'hFA00_1000, 1'b0);
        chk(wcnt, 32'h5);
        wr(32'h0C, 32'h1);
        core(32'h3000, 1'b0, 32'h0A00_3000, 32'hFA00_3000, 1'b0);
        rd(32'h0C, 32'h0400_0001);
        wr(32'h0C, 32'h0);
        wr(32'h14, 32'h0);
        core(32'h3000, 1'b0, 32'h0A00_3000, 32'hFA00_3000, 1'b0);
        chk(wcnt, 32'h6);
        wr(32'h18, 32'h0A00_3000);
        core(32'h3000, 1'b0, 32'h0A00_3000, 32'hFA00_3000, 1'b0);
        chk(wcnt, 32'h7);
        report_and_stop;
    end
endmodule
`default_nettype wire
